/* core/vafc_pkg.sv */
/*
  Package for the video adjust / FIFO control register bank: register
  offsets, field positions, reset values and the packed carriers.
  Assumes a 40 MHz register clock and an APB master with 32-bit data.
*/
package vafc_pkg;

  // Printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] IDX_EXT_OUTPUT    = 8'h04;
  localparam logic [7:0] IDX_GEN_OUTPUT    = 8'h05;
  localparam logic [7:0] IDX_FIFO_CONTROL  = 8'h07;
  localparam logic [7:0] IDX_LUMA_GAIN     = 8'h08;
  localparam logic [7:0] IDX_CHROMA_GAIN   = 8'h09;
  localparam logic [7:0] IDX_LEVEL_OFFSET  = 8'h0a;
  localparam logic [7:0] IDX_PHASE_ROT     = 8'h0b;
  localparam logic [7:0] IDX_FALLBACK_LUMA = 8'h0c;
  localparam logic [7:0] IDX_FALLBACK_CHR  = 8'h0d;
  localparam logic [7:0] IDX_OUTPUT_FORMAT = 8'h03;
  localparam logic [7:0] IDX_STATUS        = 8'h10;

  // Reset values
  localparam logic [7:0] RST_FIFO_CONTROL  = 8'h04;
  localparam logic [7:0] RST_LUMA_GAIN     = 8'h80;
  localparam logic [7:0] RST_CHROMA_GAIN   = 8'h80;
  localparam logic [7:0] RST_LEVEL_OFFSET  = 8'h00;
  localparam logic [7:0] RST_PHASE_ROT     = 8'h00;
  localparam logic [7:0] RST_FALLBACK_LUMA = 8'h10;
  localparam logic [7:0] RST_FALLBACK_CHR  = 8'h88;
  localparam logic [7:0] RST_EXT_OUTPUT    = 8'h0c;
  localparam logic [7:0] RST_GEN_OUTPUT    = 8'h00;
  localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;

  // Field positions
  localparam int FIFO_RESET_BIT   = 5;
  localparam int AUTO_RESET_BIT   = 6;
  localparam int FLAG_TIMING_BIT  = 7;
  localparam int FORCE_FB_BIT     = 0;
  localparam int AUTO_FB_BIT      = 1;
  localparam int RANGE_BIT        = 0;
  localparam int BT656_NEW_BIT    = 7;
  localparam int LOW_EN_BIT       = 4;
  localparam int HIGH_EN_BIT      = 5;
  localparam int LINE_LOCK_BIT    = 7;
  localparam int EXTRA_SEL_LSB    = 4;
  localparam int FORMAT_SEL_LSB   = 2;

  localparam int EXTRA_PINS       = 12;
  localparam int GEN_OUTS         = 4;
  localparam logic [2:0] EXTRA_NONE = 3'h0;
  localparam logic [3:0] FORMAT_GPO_A = 4'h2;   // 16-bit formats leave pins free
  localparam logic [3:0] FORMAT_GPO_B = 4'h4;

  localparam logic [3:0] LOOKUP_MAX_IDX = 4'hf;

  // Decoded pixel: luma, cb and cr
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] cb;
    logic [7:0] cr;
  } vafc_pixel_t;

  // Adjustment settings delivered to the video path
  typedef struct packed {
    logic [7:0] luma_gain;
    logic [7:0] chroma_gain;
    logic [7:0] level_offset;
    logic [7:0] phase_rotation;
    logic       full_range;
    logic       bt656_new;
  } vafc_adjust_t;

  // FIFO control delivered to the output FIFO
  typedef struct packed {
    logic [4:0] flag_margin;
    logic       flag_timing_select;
    logic       fifo_clear;
  } vafc_fifo_ctl_t;

endpackage : vafc_pkg

/* core/vafc_regs.sv */
/*
  Register bank for the output side of a video decoder: FIFO control,
  picture adjustment, fallback substitution, extended and general output
  control. Sits as an APB slave on a 40 MHz clock; the video path and FIFO
  take the settings from the struct outputs, and the decoder supplies
  lock status and field end as synchronous single-clock inputs.
*/
// Implementation choice: the APB interface to the registers.
// Notes on behaviour
// - five-bit flag margin in FIFO control
// - writing bit 5 one resets FIFO
// - FIFO reset bit clears itself
// - bit 6 resets FIFO every field end
// - bit 7 picks flag timing clock
// - eight-bit luma gain, resets to 0x80
// - chroma gain: -42, 0, +6 dB points
// - level offset, signed plus/minus 3 dB
// - phase rotation, signed plus/minus 90 degrees
// - bit 0 forces fallback values
// - bit 1 enables automatic fallback
// - auto fallback follows loss of lock
// - bits 7:2 hold fallback luma
// - range bit: studio or full codes
// - bit selects newer or older BT.656
// - extra pins select; none means undriven
// - general outputs follow programmed values, gated
// - low enable drives general outputs 0,1
// - high enable drives general outputs 2,3
// - line lock status replaces output 0
module vafc_regs (
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RST_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [11:0]           PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  input  wire logic [3:0]            PSTRB_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  input  wire logic                  VIDEO_LOCK_I,
  input  wire logic                  LINE_LOCK_I,
  input  wire logic                  FIELD_END_I,
  input  wire vafc_pkg::vafc_pixel_t PIXEL_I,
  output vafc_pkg::vafc_pixel_t      PIXEL_O,
  output vafc_pkg::vafc_adjust_t     ADJUST_O,
  output vafc_pkg::vafc_fifo_ctl_t   FIFO_CTL_O,
  output logic      [7:0]            CHROMA_GAIN_Q8_O,
  output logic      [2:0]            EXTRA_PINS_SEL_O,
  output logic      [11:0]           EXTRA_PINS_OE_N_O,
  output logic      [3:0]            GEN_OUT_O,
  output logic      [3:0]            GEN_OUT_OE_N_O
);

  logic [7:0] fifo_control;
  logic [7:0] luma_gain_control;
  logic [7:0] chroma_gain_control;
  logic [7:0] level_offset_control;
  logic [7:0] phase_rotation_control;
  logic [7:0] fallback_luma_control;
  logic [7:0] fallback_chroma_control;
  logic [7:0] ext_output_control;
  logic [7:0] gen_output_control;
  logic [7:0] output_format_control;
  logic       access;
  logic       wr_en;
  logic [9:0] word_idx;
  logic       mapped;
  logic [7:0] rd_byte;
  logic       use_fallback;
  logic       gpo_format_ok;
  logic [3:0] next_gen_out;
  logic [7:0] chroma_gain_q8;

  // Zero-wait slave: every access phase completes in its first cycle
  assign access   = PSEL_I & PENABLE_I;
  assign word_idx = PADDR_I[11:2];
  assign wr_en    = access & PWRITE_I & PSTRB_I[0] & (PADDR_I[1:0] == 2'h0);

  // Address decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (word_idx)
      {2'h0, vafc_pkg::IDX_OUTPUT_FORMAT}: rd_byte = output_format_control;
      {2'h0, vafc_pkg::IDX_EXT_OUTPUT}:    rd_byte = ext_output_control;
      {2'h0, vafc_pkg::IDX_GEN_OUTPUT}:    rd_byte = gen_output_control;
      {2'h0, vafc_pkg::IDX_FIFO_CONTROL}:  rd_byte = fifo_control;
      {2'h0, vafc_pkg::IDX_LUMA_GAIN}:     rd_byte = luma_gain_control;
      {2'h0, vafc_pkg::IDX_CHROMA_GAIN}:   rd_byte = chroma_gain_control;
      {2'h0, vafc_pkg::IDX_LEVEL_OFFSET}:  rd_byte = level_offset_control;
      {2'h0, vafc_pkg::IDX_PHASE_ROT}:     rd_byte = phase_rotation_control;
      {2'h0, vafc_pkg::IDX_FALLBACK_LUMA}: rd_byte = fallback_luma_control;
      {2'h0, vafc_pkg::IDX_FALLBACK_CHR}:  rd_byte = fallback_chroma_control;
      {2'h0, vafc_pkg::IDX_STATUS}:        rd_byte = {5'h00, LINE_LOCK_I, VIDEO_LOCK_I, use_fallback};
      default:                             mapped  = 1'b0;
    endcase
  end

  // APB answer, registered; unmapped or misaligned addresses flag an error
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & (~mapped | (PADDR_I[1:0] != 2'h0));
      if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
        PRDATA_O <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Writes land only in the completing access cycle (PREADY_O high)
  function automatic logic hit(input logic [7:0] idx);
    hit = wr_en & PREADY_O & (word_idx == {2'h0, idx});
  endfunction : hit

  // FIFO control; the reset bit is a one-shot so software never clears it
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fifo_control <= vafc_pkg::RST_FIFO_CONTROL;
    end else if (hit(vafc_pkg::IDX_FIFO_CONTROL)) begin
      fifo_control <= PWDATA_I[7:0];
    end else begin
      fifo_control[vafc_pkg::FIFO_RESET_BIT] <= 1'b0;
    end
  end

  // Picture adjustment registers; signed codes pass to the video path as is
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      luma_gain_control      <= vafc_pkg::RST_LUMA_GAIN;
      chroma_gain_control    <= vafc_pkg::RST_CHROMA_GAIN;
      level_offset_control   <= vafc_pkg::RST_LEVEL_OFFSET;
      phase_rotation_control <= vafc_pkg::RST_PHASE_ROT;
    end else begin
      if (hit(vafc_pkg::IDX_LUMA_GAIN))    luma_gain_control      <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_CHROMA_GAIN))  chroma_gain_control    <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_LEVEL_OFFSET)) level_offset_control   <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_PHASE_ROT))    phase_rotation_control <= PWDATA_I[7:0];
    end
  end

  // Fallback and output-control registers
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fallback_luma_control   <= vafc_pkg::RST_FALLBACK_LUMA;
      fallback_chroma_control <= vafc_pkg::RST_FALLBACK_CHR;
      ext_output_control      <= vafc_pkg::RST_EXT_OUTPUT;
      gen_output_control      <= vafc_pkg::RST_GEN_OUTPUT;
      output_format_control   <= vafc_pkg::RST_OUTPUT_FORMAT;
    end else begin
      if (hit(vafc_pkg::IDX_FALLBACK_LUMA)) fallback_luma_control   <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_FALLBACK_CHR))  fallback_chroma_control <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_EXT_OUTPUT))    ext_output_control      <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_GEN_OUTPUT))    gen_output_control      <= PWDATA_I[7:0];
      if (hit(vafc_pkg::IDX_OUTPUT_FORMAT)) output_format_control   <= PWDATA_I[7:0];
    end
  end

  // FIFO control to the FIFO; a clear is a pulse from either source
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FIFO_CTL_O <= '0;
    end else begin
      FIFO_CTL_O.flag_margin        <= fifo_control[4:0];
      FIFO_CTL_O.flag_timing_select <= fifo_control[vafc_pkg::FLAG_TIMING_BIT];
      FIFO_CTL_O.fifo_clear         <= fifo_control[vafc_pkg::FIFO_RESET_BIT]
                                     | (fifo_control[vafc_pkg::AUTO_RESET_BIT] & FIELD_END_I);
    end
  end

  // Adjust settings to the video path
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ADJUST_O <= '0;
    end else begin
      ADJUST_O.luma_gain      <= luma_gain_control;
      ADJUST_O.chroma_gain    <= chroma_gain_control;
      ADJUST_O.level_offset   <= level_offset_control;
      ADJUST_O.phase_rotation <= phase_rotation_control;
      ADJUST_O.full_range     <= ext_output_control[vafc_pkg::RANGE_BIT];
      ADJUST_O.bt656_new      <= ext_output_control[vafc_pkg::BT656_NEW_BIT];
    end
  end

  // Piecewise-linear linear gain, Q1.7: code 0 is about -42 dB (1/128),
  // 0x80 unity, 0xFF near 2x (+6 dB). Linear pieces keep it monotonic.
  always_comb begin
    if (chroma_gain_control[7]) begin
      chroma_gain_q8 = {1'b1, chroma_gain_control[6:0]};
    end else begin
      chroma_gain_q8 = {1'b0, chroma_gain_control[6:0]} + 8'h01;
    end
  end

  // Fallback substitution: forced, or automatic while lock is lost
  assign use_fallback = fallback_luma_control[vafc_pkg::FORCE_FB_BIT]
                      | (fallback_luma_control[vafc_pkg::AUTO_FB_BIT] & ~VIDEO_LOCK_I);

  // Pixel output register; fallback luma gets two zero LSBs, chroma nibbles
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PIXEL_O          <= '0;
      CHROMA_GAIN_Q8_O <= 8'h00;
    end else begin
      CHROMA_GAIN_Q8_O <= chroma_gain_q8;
      if (use_fallback) begin
        PIXEL_O.luma <= {fallback_luma_control[7:2], 2'h0};
        PIXEL_O.cr   <= {fallback_chroma_control[7:4], 4'h0};
        PIXEL_O.cb   <= {fallback_chroma_control[3:0], 4'h0};
      end else begin
        PIXEL_O <= PIXEL_I;
      end
    end
  end

  // Extra pins: the "none" selection releases all twelve drivers
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      EXTRA_PINS_SEL_O  <= vafc_pkg::EXTRA_NONE;
      EXTRA_PINS_OE_N_O <= 12'hfff;
    end else begin
      EXTRA_PINS_SEL_O  <= ext_output_control[vafc_pkg::EXTRA_SEL_LSB +: 3];
      EXTRA_PINS_OE_N_O <= {vafc_pkg::EXTRA_PINS{ext_output_control[vafc_pkg::EXTRA_SEL_LSB +: 3]
                                                 == vafc_pkg::EXTRA_NONE}};
    end
  end

  // General outputs only exist in formats that leave those pins free
  assign gpo_format_ok =
    (output_format_control[vafc_pkg::FORMAT_SEL_LSB +: 4] == vafc_pkg::FORMAT_GPO_A) |
    (output_format_control[vafc_pkg::FORMAT_SEL_LSB +: 4] == vafc_pkg::FORMAT_GPO_B);

  // Output 0 shows line lock instead of its bit when enabled
  always_comb begin
    next_gen_out = gen_output_control[3:0];
    if (gen_output_control[vafc_pkg::LINE_LOCK_BIT]) begin
      next_gen_out[0] = LINE_LOCK_I;
    end
  end

  // One driver enable per pin; pairs share the low or high enable bit
  for (genvar g = 0; g < vafc_pkg::GEN_OUTS; g++) begin : g_gen_out
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        GEN_OUT_O[g]      <= 1'b0;
        GEN_OUT_OE_N_O[g] <= 1'b1;
      end else begin
        GEN_OUT_O[g]      <= next_gen_out[g];
        GEN_OUT_OE_N_O[g] <= ~(gpo_format_ok &
                              gen_output_control[(g < 2) ? vafc_pkg::LOW_EN_BIT
                                                         : vafc_pkg::HIGH_EN_BIT]);
      end
    end
  end

endmodule : vafc_regs

/* test/vafc_props.sv */
/*
  Checker for the register bank: APB answer, FIFO clears, fallback pixels
  and pin drivers. Assumes it is bound to vafc_regs and sees only its ports.
*/
module vafc_props (
  input wire logic                     REF_CLK_I,
  input wire logic                     RST_I,
  input wire logic                     PSEL_I,
  input wire logic                     PENABLE_I,
  input wire logic                     PWRITE_I,
  input wire logic [11:0]              PADDR_I,
  input wire logic [31:0]              PWDATA_I,
  input wire logic [3:0]               PSTRB_I,
  input wire logic                     PREADY_O,
  input wire logic                     PSLVERR_O,
  input wire logic                     VIDEO_LOCK_I,
  input wire logic                     LINE_LOCK_I,
  input wire logic                     FIELD_END_I,
  input wire vafc_pkg::vafc_pixel_t    PIXEL_I,
  input wire vafc_pkg::vafc_pixel_t    PIXEL_O,
  input wire vafc_pkg::vafc_fifo_ctl_t FIFO_CTL_O,
  input wire logic [11:0]              EXTRA_PINS_OE_N_O,
  input wire logic [2:0]               EXTRA_PINS_SEL_O,
  input wire logic [3:0]               GEN_OUT_O,
  input wire logic [3:0]               GEN_OUT_OE_N_O
);
  logic [7:0] fc, fb, gp, of;
  logic       wr, clr_wr, elig;
  logic [3:0] oe_n;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // A write lands only at an accepted, error-free access with lane 0 on
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && !PSLVERR_O && PSTRB_I[0];
  assign clr_wr = wr && PADDR_I == 12'h01C && PWDATA_I[5];
  assign elig = of[5:2] == 4'h2 || of[5:2] == 4'h4;
  assign oe_n = {{2{!(elig && gp[5])}}, {2{!(elig && gp[4])}}};
  // Shadow copies of the registers that steer the outputs
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fc <= vafc_pkg::RST_FIFO_CONTROL;
      fb <= vafc_pkg::RST_FALLBACK_LUMA;
      gp <= vafc_pkg::RST_GEN_OUTPUT;
      of <= vafc_pkg::RST_OUTPUT_FORMAT;
    end else if (wr) begin
      if (PADDR_I == 12'h01C) fc <= PWDATA_I[7:0];
      if (PADDR_I == 12'h030) fb <= PWDATA_I[7:0];
      if (PADDR_I == 12'h014) gp <= PWDATA_I[7:0];
      if (PADDR_I == 12'h00C) of <= PWDATA_I[7:0];
    end
  end
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_access;
    PREADY_O && PENABLE_I;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no answer one cycle after setup");
  a_error_misalign: assert property ((s_setup and (PADDR_I[1:0] != 2'b00)) |=> PSLVERR_O && PREADY_O)
    else $error("misaligned access not refused");
  a_clear_manual: assert property (clr_wr |-> ##2 FIFO_CTL_O.fifo_clear)
    else $error("fifo clear missing after request");
  a_clear_cause: assert property (FIFO_CTL_O.fifo_clear |-> $past(FIELD_END_I && fc[6]) || $past(clr_wr, 2))
    else $error("fifo clear without cause");
  a_margin_follows: assert property (1'b1 |=> {FIFO_CTL_O.flag_margin, FIFO_CTL_O.flag_timing_select}
    == $past({fc[4:0], fc[7]}))
    else $error("flag margin or timing wrong");
  a_fallback_pass: assert property (!fb[0] && !(fb[1] && !VIDEO_LOCK_I) |=> PIXEL_O == $past(PIXEL_I))
    else $error("decoded pixel not passed");
  a_fallback_luma: assert property (fb[0] |=> PIXEL_O.luma == {$past(fb[7:2]), 2'b00})
    else $error("fallback luma wrong");
  a_extra_none: assert property (EXTRA_PINS_SEL_O == 3'h0 |-> EXTRA_PINS_OE_N_O == 12'hFFF)
    else $error("extra pins driven with no data");
  a_gen_drive: assert property (1'b1 |=> GEN_OUT_OE_N_O == $past(oe_n))
    else $error("general output drivers wrong");
  a_line_lock_pin: assert property (gp[7] |=> GEN_OUT_O[0] == $past(LINE_LOCK_I))
    else $error("line lock not on output 0");
endmodule : vafc_props
bind vafc_regs vafc_props u_props (.*);

/* test/vafc_sink.sv */
/*
  Downstream video processor model: takes FIFO control and
  counts clear pulses. Assumes the clock and reset of the register bank.
*/
module vafc_sink (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire vafc_pkg::vafc_fifo_ctl_t fifo_ctl_i,
  output logic [7:0]                    clear_count_o
);
  // Every cycle of clear counts, so a stuck pulse shows as a large count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_count_o <= 8'h00;
    end else if (fifo_ctl_i.fifo_clear) begin
      clear_count_o <= clear_count_o + 8'h01;
    end
  end
endmodule : vafc_sink

/* test/tb_video_adjust_fifo_control_regs.sv */
/*
  Self-checking bench for the register bank over APB.
  Assumes the package, bank, sink model and checker compile before it.
*/
module tb_video_adjust_fifo_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, rst, psel, penable, pwrite, lock, hlock, fend, err, pready, pslverr;
  logic [11:0]              paddr, xoe_n;
  logic [31:0]              pwdata, rdata, prdata;
  logic [3:0]               pstrb, gout, goe_n;
  logic [7:0]               gain, clears, c0;
  logic [2:0]               xsel;
  vafc_pkg::vafc_pixel_t    pix_i, pix_o;
  vafc_pkg::vafc_adjust_t   adj;
  vafc_pkg::vafc_fifo_ctl_t fctl;
  int                       fails, comparisons, i, k;
  logic [7:0]               ri [6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  logic [7:0]               rv [6] = '{8'h04, 8'h80, vafc_pkg::RST_CHROMA_GAIN, vafc_pkg::RST_LEVEL_OFFSET,
                                       vafc_pkg::RST_PHASE_ROT, 8'h10};
  logic [7:0]               codes [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  vafc_regs dut_u (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .VIDEO_LOCK_I(lock), .LINE_LOCK_I(hlock), .FIELD_END_I(fend), .PIXEL_I(pix_i),
    .PIXEL_O(pix_o), .ADJUST_O(adj), .FIFO_CTL_O(fctl), .CHROMA_GAIN_Q8_O(gain), .EXTRA_PINS_SEL_O(xsel),
    .EXTRA_PINS_OE_N_O(xoe_n), .GEN_OUT_O(gout), .GEN_OUT_OE_N_O(goe_n));
  vafc_sink sink_u (.clk_i(clk), .rst_i(rst), .fifo_ctl_i(fctl), .clear_count_o(clears));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // One APB transfer; a hung slave ends the run through the bound
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      finish_test();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic field();
    @(posedge clk);
    fend <= 1'b1;
    @(posedge clk);
    fend <= 1'b0;
    idle(4);
  endtask : field
  // Main sequence
  initial begin
    // Start locked, no field end, bus idle
    {rst, psel, penable, pwrite, lock, hlock, fend, paddr, pwdata} = {1'b1, 6'h04, 44'h0};
    {pstrb, pix_i, fails, comparisons} = {4'hF, 24'h3C_5A7E, 64'h0};
    idle(2);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      bus(0, {2'b00, ri[i], 2'b00}, 8'h00);
      chk("reset value", rdata, {24'h00_0000, rv[i]});
    end
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      for (i = 1; i < 5; i++) bus(1, {2'b00, ri[i], 2'b00}, codes[k]);
      for (i = 1; i < 5; i++) begin
        bus(0, {2'b00, ri[i], 2'b00}, 8'h00);
        chk("adjust readback", rdata, {24'h00_0000, codes[k]});
      end
      chk("adjust out", adj[33:2], {4{codes[k]}});
      chk("chroma gain", gain, codes[k] < 8'h80 ? codes[k] + 8'h01 : codes[k]);
    end
    $display("test adjust done");
    bus(1, 12'h01C, 8'h9F);
    idle(4);
    chk("flag margin", fctl, {5'h1F, 1'b1, 1'b0});
    c0 = clears;
    bus(1, 12'h01C, 8'hBF);
    idle(4);
    chk("manual clear", clears, c0 + 8'h01);
    bus(0, 12'h01C, 8'h00);
    chk("request bit", rdata, 32'h0000_009F);
    field();
    chk("no auto clear", clears, c0 + 8'h01);
    bus(1, 12'h01C, 8'hDF);
    field();
    chk("auto clear", clears, c0 + 8'h02);
    $display("test fifo done");
    bus(1, 12'h034, 8'h5C);
    bus(1, 12'h030, 8'hA9);
    idle(4);
    chk("forced pixel", pix_o, 24'hA8_C050);
    bus(1, 12'h030, 8'hAA);
    idle(4);
    chk("locked pixel", pix_o, pix_i);
    lock <= 1'b0;
    idle(4);
    chk("unlocked pixel", pix_o, 24'hA8_C050);
    bus(1, 12'h030, 8'hA8);
    idle(4);
    chk("auto off pixel", pix_o, pix_i);
    lock <= 1'b1;
    $display("test fallback done");
    bus(1, 12'h010, 8'h8D);
    idle(4);
    chk("range codes", adj[1:0], 2'b11);
    chk("extra pins off", xoe_n, 12'hFFF);
    bus(1, 12'h010, 8'h1C);
    idle(4);
    chk("extra select", {adj[1:0], xsel}, 5'h01);
    bus(1, 12'h00C, 8'h08);
    bus(1, 12'h014, 8'h1A);
    idle(4);
    chk("low drivers", {goe_n, gout}, 8'hCA);
    bus(1, 12'h014, 8'h25);
    idle(4);
    chk("high drivers", {goe_n, gout}, 8'h35);
    bus(1, 12'h00C, 8'h00);
    idle(4);
    chk("format gate", goe_n, 4'hF);
    bus(1, 12'h00C, 8'h10);
    bus(1, 12'h014, 8'h90);
    hlock <= 1'b1;
    idle(4);
    chk("line lock high", gout[0], 1'b1);
    hlock <= 1'b0;
    idle(4);
    chk("line lock low", gout[0], 1'b0);
    bus(0, 12'h040, 8'h00);
    chk("status word", {rdata[30:0], err}, 32'h0000_0004);
    $display("test pins done");
    bus(0, 12'h03C, 8'h00);
    chk("unmapped read", {rdata[30:0], err}, 32'h0000_0001);
    bus(1, 12'h021, 8'h55);
    chk("misaligned write", err, 1'b1);
    pstrb <= 4'h0;
    bus(1, 12'h020, 8'h11);
    pstrb <= 4'hF;
    bus(0, 12'h020, 8'h00);
    chk("refused writes", {rdata[30:0], err}, 32'h0000_01FE);
    $display("test refusal done");
    finish_test();
  end
endmodule : tb_video_adjust_fifo_control_regs
